// ### logic/bsc_pkg.sv
// Purpose: shared constants, encodings and types of the bcd serial core
// Assumes: 12-bit micro-instructions, 25-digit words, one digit per clock
// Notes: the named constants the core uses live here; plain literals stay in the modules
package bsc_pkg;

  // ****************************************************************
  // word and bus geometry
  // ****************************************************************
  localparam int INST_W = 12;
  localparam int ADDR_W = 8;
  localparam int BANK_W = 5;
  localparam int DIG_W = 5;
  localparam int DIGITS = 25;
  localparam int MEM_AW = 7;
  localparam logic [4:0] LAST_DIG = 5'h18; // digit 24, most significant
  localparam logic [4:0] WORD_END = 5'h19; // one past the last digit
  localparam logic [4:0] POINTER_MAX = 5'h18;
  localparam logic [1:0] ACC_REG = 2'h0; // register 0 is the accumulator

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PC_RST = 8'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [4:0] POINTER_RST = 5'h00;
  localparam logic [24:0] FLAGS_RST = 25'h0000000;

  // ****************************************************************
  // arithmetic opcodes, inst[10:7] when inst[11] is 0
  // ****************************************************************
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_SWAP = 4'h2;
  localparam logic [3:0] OP_NEG = 4'h3;
  localparam logic [3:0] OP_INC = 4'h4;
  localparam logic [3:0] OP_DEC = 4'h5;
  localparam logic [3:0] OP_SHL = 4'h6;
  localparam logic [3:0] OP_SHR = 4'h7;
  localparam logic [3:0] OP_CLR = 4'h8;
  localparam logic [3:0] OP_SLI = 4'h9;

  // ****************************************************************
  // non-arithmetic classes, inst[10:9] when inst[11] is 1
  // ****************************************************************
  localparam logic [1:0] CL_BRANCH = 2'h0;
  localparam logic [1:0] CL_CTRL = 2'h1;
  localparam logic [1:0] CL_EXT = 2'h2;
  localparam logic [1:0] CL_MISC = 2'h3;

  // ****************************************************************
  // control sub-opcodes, inst[8:5]; operand in inst[4:0]
  // ****************************************************************
  localparam logic [3:0] C_SET = 4'h0;
  localparam logic [3:0] C_RESET = 4'h1;
  localparam logic [3:0] C_CLEAR = 4'h2;
  localparam logic [3:0] C_QUERY = 4'h3;
  localparam logic [3:0] C_TOGGLE = 4'h4;
  localparam logic [3:0] C_BSWAP = 4'h5;
  localparam logic [3:0] C_LATCH = 4'h6;
  localparam logic [3:0] C_CFORCE = 4'h7;
  localparam logic [3:0] C_CQUERY = 4'h8;
  localparam logic [3:0] C_LEFT = 4'h9;
  localparam logic [3:0] C_RIGHT = 4'hA;
  localparam logic [3:0] C_SAVEA = 4'hB;
  localparam logic [3:0] C_SAVEB = 4'hC;
  localparam logic [3:0] C_RESTA = 4'hD;
  localparam logic [3:0] C_RESTB = 4'hE;

  // ****************************************************************
  // test outcomes steering the next branch
  // ****************************************************************
  localparam logic [1:0] RES_MATCH = 2'h0;
  localparam logic [1:0] RES_SECOND = 2'h1;
  localparam logic [1:0] RES_NONE = 2'h2;

  // ****************************************************************
  // field window patterns, bit n enables digit n
  // ****************************************************************
  localparam logic [24:0] WIN_MASK [0:7] = '{
    25'h1FFFFFF, 25'h0000001, 25'h0000007, 25'h0FFFFF8,
    25'h1000000, 25'h0FFFFFF, 25'h1FFFFFF, 25'h1FFFFFF};

  // ****************************************************************
  // sequencer states, gray along fetch-latch-decode-exec
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_LATCH = 2'b01,
    ST_DECODE = 2'b11,
    ST_EXEC = 2'b10
  } bsc_state_e;

endpackage

// ### logic/bsc_mem_if.sv
// Purpose: carrier between the core and its digit memory
// Assumes: two registered read ports, two write ports
// Notes: write port b wins when both hit one address
`timescale 1ns/1ns
`default_nettype none
interface bsc_mem_if;
  import bsc_pkg::*;
  logic [MEM_AW-1:0] ra_addr;
  logic [MEM_AW-1:0] rb_addr;
  logic [3:0] ra_data;
  logic [3:0] rb_data;
  logic wa_en;
  logic [MEM_AW-1:0] wa_addr;
  logic [3:0] wa_data;
  logic wb_en;
  logic [MEM_AW-1:0] wb_addr;
  logic [3:0] wb_data;
  modport core (output ra_addr, rb_addr, wa_en, wa_addr, wa_data, wb_en, wb_addr, wb_data,
                input ra_data, rb_data);
  modport mem (input ra_addr, rb_addr, wa_en, wa_addr, wa_data, wb_en, wb_addr, wb_data,
               output ra_data, rb_data);
endinterface
`default_nettype wire

// ### logic/bsc_digit_mem.sv
// Purpose: digit store for the accumulator and three memory registers
// Assumes: address is {register, digit}; unused digits 25..31 are dead
// Notes: read data come out one clock after the address
`timescale 1ns/1ns
`default_nettype none
module bsc_digit_mem (
  input wire logic clk_in, // core clock
  input wire logic resetn_in, // synchronous, active low
  bsc_mem_if.mem mem_port // read and write ports
);
  import bsc_pkg::*;

  logic [3:0] store_r [0:(1<<MEM_AW)-1];
  logic [3:0] ra_r;
  logic [3:0] rb_r;

  // storage writes, port b last so it wins
  always_ff @(posedge clk_in) begin
    if (mem_port.wa_en) begin
      store_r[mem_port.wa_addr] <= mem_port.wa_data;
    end
    if (mem_port.wb_en) begin
      store_r[mem_port.wb_addr] <= mem_port.wb_data;
    end
  end

  // registered reads
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ra_r <= 4'h0;
      rb_r <= 4'h0;
    end else begin
      ra_r <= store_r[mem_port.ra_addr];
      rb_r <= store_r[mem_port.rb_addr];
    end
  end

  assign mem_port.ra_data = ra_r;
  assign mem_port.rb_data = rb_r;
endmodule
`default_nettype wire

// ### logic/bsc_digit_alu.sv
// Purpose: one-digit decimal adder and subtractor
// Assumes: operands are valid bcd digits
// Notes: carry_in is a borrow when sub_in is high
`timescale 1ns/1ns
`default_nettype none
module bsc_digit_alu (
  input wire logic [3:0] a_in, // addend or minuend
  input wire logic [3:0] b_in, // addend or subtrahend
  input wire logic carry_in, // carry or borrow in
  input wire logic sub_in, // high to subtract
  output logic [3:0] sum_out, // decimal result digit
  output logic carry_out // carry or borrow out
);
  logic [4:0] add_raw;
  logic [4:0] sub_raw;
  logic add_ovf;
  logic sub_neg;

  // binary sum and difference, then decimal correction
  assign add_raw = {1'b0, a_in} + {1'b0, b_in} + {4'h0, carry_in};
  assign sub_raw = {1'b0, a_in} - {1'b0, b_in} - {4'h0, carry_in};
  assign add_ovf = add_raw > 5'h09;
  assign sub_neg = sub_raw[4];
  assign sum_out = sub_in ? (sub_neg ? sub_raw[3:0] + 4'hA : sub_raw[3:0])
                          : (add_ovf ? add_raw[3:0] + 4'h6 : add_raw[3:0]);
  assign carry_out = sub_in ? sub_neg : add_ovf;
endmodule
`default_nettype wire

// ### logic/bsc_core_top.sv
// Purpose: micro-instruction sequencer and digit-serial arithmetic core
// Assumes: rom answers in the cycle rom_read_out is high
// Notes: one digit per clock, least significant digit first
//
// Contract
// - sum: accumulator plus source into destination
// - difference: accumulator minus source into destination
// - swap: accumulator to destination, source to accumulator
// - negate: zero minus source into destination
// - plus or minus one: source into destination
// - shift up one digit, zero fill low
// - shift down one digit, zero fill high
// - zero every digit of selected register
// - shift accumulator up, literal into low digit
// - bank select picks rom for later fetches
// - branch conditional after test, else always
// - set or reset one named flag only
// - clear all 25 flags at once
// - flag query result conditions next branch
// - flag toggle conditional after test, else always
// - swap the two flag registers whole
// - latch mode switch inputs into flags
// - force cursor to one of 25 positions
// - cursor steps one left or right, wrapping 24 to 0 and 0 to 24
// - save two addresses, restore each into counter
// - one 8-bit address to all roms
// - six field windows limit execution digits
// - 25 digits, four bits parallel, lsd first
`timescale 1ns/1ns
`default_nettype none
module bsc_core_top (
  input wire logic sys_clk_in, // core clock, 125 MHz
  input wire logic resetn_in, // synchronous, active low
  input wire logic [bsc_pkg::INST_W-1:0] rom_data_in, // selected rom word
  input wire logic [24:0] mode_switch_in, // mode switch levels
  output logic [bsc_pkg::ADDR_W-1:0] rom_addr_out, // fetch address to all roms
  output logic [bsc_pkg::BANK_W-1:0] rom_bank_out, // selected rom
  output logic rom_read_out, // fetch strobe
  output logic word_sync_out, // start of a word time
  output logic field_window_out, // digit written inside window
  output logic [3:0] result_digit_out, // digit being written
  output logic result_valid_out, // result_digit_out is valid
  output logic [24:0] flags_out, // active flag register
  output logic [bsc_pkg::DIG_W-1:0] pointer_out, // cursor position
  output logic [5:0] ext_cmd_out, // external port command code
  output logic ext_strobe_out // external command pulse
);
  import bsc_pkg::*;
  // ****************************************************************
  // state
  // ****************************************************************
  bsc_state_e state_r;
  logic [ADDR_W-1:0] pc_r;
  logic [BANK_W-1:0] bank_r;
  logic rom_read_r;
  logic [INST_W-1:0] instr_r;
  logic [DIG_W-1:0] dig_r;
  logic carry_r;
  logic zero_a_r;
  logic zero_b_r;
  logic [24:0] flags_a_r;
  logic [24:0] flags_b_r;
  logic [DIG_W-1:0] pointer_r;
  logic [ADDR_W-1:0] save_a_r;
  logic [ADDR_W-1:0] save_b_r;
  logic test_pend_r;
  logic [1:0] result_r;
  logic mode3_r;
  logic sync_r;
  logic win_r;
  logic [3:0] res_dig_r;
  logic res_valid_r;
  logic [5:0] ext_cmd_r;
  logic ext_strobe_r;

  bsc_mem_if mif ();
  bsc_digit_mem u_mem (
    .clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .mem_port(mif.mem)
  );

  // ****************************************************************
  // instruction fields
  // ****************************************************************
  wire logic is_arith = ~instr_r[11];
  wire logic [3:0] aop = instr_r[10:7];
  wire logic [1:0] src_sel = instr_r[6:5];
  wire logic [1:0] dst_sel = instr_r[4:3];
  wire logic [2:0] win_code = instr_r[2:0];
  wire logic [3:0] literal = instr_r[6:3];
  wire logic [1:0] cls = instr_r[10:9];
  wire logic [3:0] cop = instr_r[8:5];
  wire logic [4:0] operand = instr_r[4:0];
  wire logic [7:0] target = instr_r[7:0];
  wire logic arith_ok = aop <= OP_SLI;
  wire logic [24:0] flag_bit = 25'h0000001 << operand;
  // toggle condition: always taken unless a test just ran
  wire logic take_w = ~test_pend_r | (result_r == RES_MATCH);

  // ****************************************************************
  // digit read side
  // ****************************************************************
  wire logic op_shl = aop == OP_SHL;
  wire logic op_shr = aop == OP_SHR;
  wire logic op_sli = aop == OP_SLI;
  wire logic [4:0] dig_dn = dig_r - 5'h01;
  wire logic [4:0] dig_up = dig_r + 5'h01;
  // shifts read the neighbour digit, edges read as zero
  wire logic [4:0] a_dig = op_sli ? dig_dn : dig_r;
  wire logic [4:0] b_dig = op_shl ? dig_dn : (op_shr ? dig_up : dig_r);
  wire logic a_oor = op_sli && (dig_r == 5'h00);
  wire logic b_oor = (op_shl && (dig_r == 5'h00)) || (op_shr && (dig_r == LAST_DIG));
  assign mif.ra_addr = {ACC_REG, a_dig};
  assign mif.rb_addr = {src_sel, b_dig};

  // ****************************************************************
  // digit write side, one clock behind the read
  // ****************************************************************
  wire logic [4:0] wr_dig = dig_dn;
  wire logic wr_phase = (state_r == ST_EXEC) && (dig_r != 5'h00);
  wire logic in_win = wr_phase && WIN_MASK[win_code][wr_dig];
  wire logic [3:0] a_val = zero_a_r ? 4'h0 : mif.ra_data;
  wire logic [3:0] b_val = zero_b_r ? 4'h0 : mif.rb_data;
  wire logic op_two = (aop == OP_ADD) || (aop == OP_SUB);
  wire logic op_one = (aop == OP_INC) || (aop == OP_DEC);
  wire logic op_math = op_two || op_one || (aop == OP_NEG);
  wire logic op_sub = (aop == OP_SUB) || (aop == OP_NEG) || (aop == OP_DEC);
  wire logic [3:0] alu_a = op_two ? a_val : (op_one ? b_val : 4'h0);
  wire logic [3:0] alu_b = op_one ? 4'h0 : b_val;
  logic [3:0] alu_sum;
  logic alu_cout;
  bsc_digit_alu u_alu (
    .a_in(alu_a),
    .b_in(alu_b),
    .carry_in(carry_r),
    .sub_in(op_sub),
    .sum_out(alu_sum),
    .carry_out(alu_cout)
  );
  // destination data per operation
  wire logic [3:0] wa_val = op_math ? alu_sum :
                            (aop == OP_SWAP) ? a_val :
                            (op_shl || op_shr) ? b_val :
                            (aop == OP_CLR) ? 4'h0 :
                            (wr_dig == 5'h00) ? literal : a_val;
  wire logic [1:0] wa_reg = (op_shl || op_shr || (aop == OP_CLR)) ? src_sel :
                            op_sli ? ACC_REG : dst_sel;
  assign mif.wa_en = in_win && arith_ok;
  assign mif.wa_addr = {wa_reg, wr_dig};
  assign mif.wa_data = wa_val;
  // swap also loads the source into the accumulator
  assign mif.wb_en = in_win && (aop == OP_SWAP);
  assign mif.wb_addr = {ACC_REG, wr_dig};
  assign mif.wb_data = b_val;

  // ****************************************************************
  // branch target and sequential address
  // ****************************************************************
  wire logic [7:0] target_nxt = target + 8'h01;
  wire logic [7:0] br_dest = ~test_pend_r ? target :
                             (result_r == RES_MATCH) ? target :
                             (result_r == RES_SECOND && mode3_r) ? target_nxt : pc_r;
  wire logic cur_lt = pointer_r < operand;
  wire logic cur_eq = pointer_r == operand;
  wire logic [4:0] ptr_left = (pointer_r == POINTER_MAX) ? 5'h00 : pointer_r + 5'h01;
  wire logic [4:0] ptr_right = (pointer_r == 5'h00) ? POINTER_MAX : pointer_r - 5'h01;
  wire logic is_ctrl = ~is_arith && (cls == CL_CTRL);
  wire logic is_query = is_ctrl && ((cop == C_QUERY) || (cop == C_CQUERY));

  // ****************************************************************
  // sequencer: fetch, latch, decode, digit loop
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_FETCH;
      rom_read_r <= 1'b0;
      instr_r <= 12'h000;
      dig_r <= 5'h00;
      sync_r <= 1'b0;
    end else begin
      sync_r <= 1'b0;
      rom_read_r <= 1'b0;
      case (state_r)
        ST_FETCH: begin
          rom_read_r <= 1'b1;
          state_r <= ST_LATCH;
        end
        ST_LATCH: begin
          instr_r <= rom_data_in;
          state_r <= ST_DECODE;
        end
        ST_DECODE: begin
          dig_r <= 5'h00;
          if (is_arith && arith_ok) begin
            sync_r <= 1'b1;
            state_r <= ST_EXEC;
          end else begin
            state_r <= ST_FETCH;
          end
        end
        default: begin
          dig_r <= dig_up;
          if (dig_r == WORD_END) begin
            state_r <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // address counter, rom bank and saved addresses
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pc_r <= PC_RST;
      bank_r <= BANK_RST;
      save_a_r <= PC_RST;
      save_b_r <= PC_RST;
      mode3_r <= 1'b0;
    end else if (state_r == ST_LATCH) begin
      pc_r <= pc_r + 8'h01;
    end else if (state_r == ST_DECODE && ~is_arith) begin
      if (cls == CL_BRANCH && ~instr_r[8]) begin
        pc_r <= br_dest;
        mode3_r <= 1'b0;
      end else if (cls == CL_BRANCH) begin
        mode3_r <= instr_r[0];
      end else if (cls == CL_MISC && instr_r[8]) begin
        bank_r <= operand;
      end else if (is_ctrl && cop == C_SAVEA) begin
        save_a_r <= pc_r;
      end else if (is_ctrl && cop == C_SAVEB) begin
        save_b_r <= pc_r;
      end else if (is_ctrl && cop == C_RESTA) begin
        pc_r <= save_a_r;
      end else if (is_ctrl && cop == C_RESTB) begin
        pc_r <= save_b_r;
      end
    end
  end

  // ****************************************************************
  // flag registers and cursor
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      flags_a_r <= FLAGS_RST;
      flags_b_r <= FLAGS_RST;
      pointer_r <= POINTER_RST;
    end else if (state_r == ST_DECODE && is_ctrl) begin
      case (cop)
        C_SET: flags_a_r <= flags_a_r | flag_bit;
        C_RESET: flags_a_r <= flags_a_r & ~flag_bit;
        C_CLEAR: flags_a_r <= FLAGS_RST;
        C_TOGGLE: flags_a_r <= take_w ? flags_a_r ^ flag_bit : flags_a_r;
        C_BSWAP: begin
          flags_a_r <= flags_b_r;
          flags_b_r <= flags_a_r;
        end
        C_LATCH: flags_b_r <= mode_switch_in;
        C_CFORCE: pointer_r <= (operand > POINTER_MAX) ? pointer_r : operand;
        C_LEFT: pointer_r <= ptr_left;
        C_RIGHT: pointer_r <= ptr_right;
        default: pointer_r <= pointer_r;
      endcase
    end
  end

  // ****************************************************************
  // test outcome kept for the following branch
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      test_pend_r <= 1'b0;
      result_r <= RES_NONE;
    end else if (state_r == ST_DECODE) begin
      test_pend_r <= is_query;
      if (is_query && cop == C_QUERY) begin
        result_r <= |(flags_a_r & flag_bit) ? RES_MATCH : RES_NONE;
      end else if (is_query) begin
        result_r <= cur_eq ? RES_MATCH : (cur_lt ? RES_SECOND : RES_NONE);
      end
    end
  end

  // ****************************************************************
  // carry chain and edge-zero pipeline
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      carry_r <= 1'b0;
      zero_a_r <= 1'b0;
      zero_b_r <= 1'b0;
    end else begin
      zero_a_r <= a_oor;
      zero_b_r <= b_oor;
      if (state_r == ST_DECODE) begin
        carry_r <= op_one;
      end else if (in_win && op_math) begin
        carry_r <= alu_cout;
      end
    end
  end

  // ****************************************************************
  // observation and external command outputs
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      win_r <= 1'b0;
      res_dig_r <= 4'h0;
      res_valid_r <= 1'b0;
      ext_cmd_r <= 6'h00;
      ext_strobe_r <= 1'b0;
    end else begin
      win_r <= in_win;
      res_valid_r <= mif.wa_en;
      res_dig_r <= mif.wa_en ? wa_val : res_dig_r;
      ext_strobe_r <= (state_r == ST_DECODE) && ~is_arith && (cls == CL_EXT);
      ext_cmd_r <= ((state_r == ST_DECODE) && ~is_arith && (cls == CL_EXT)) ? instr_r[5:0] : ext_cmd_r;
    end
  end

  assign rom_addr_out = pc_r;
  assign rom_bank_out = bank_r;
  assign rom_read_out = rom_read_r;
  assign word_sync_out = sync_r;
  assign field_window_out = win_r;
  assign result_digit_out = res_dig_r;
  assign result_valid_out = res_valid_r;
  assign flags_out = flags_a_r;
  assign pointer_out = pointer_r;
  assign ext_cmd_out = ext_cmd_r;
  assign ext_strobe_out = ext_strobe_r;
endmodule
`default_nettype wire

// ### verification/bsc_core_props.sv
// Purpose: port checks of the bcd serial core
// Assumes: sees only bsc_core_top ports
// Notes: bound to the core after the module
`timescale 1ns/1ns
`default_nettype none
module bsc_core_props (
  input wire logic sys_clk_in, // core clock
  input wire logic resetn_in, // sync reset, low
  input wire logic rom_read_out, // fetch strobe
  input wire logic word_sync_out, // word start
  input wire logic result_valid_out, // digit written
  input wire logic ext_strobe_out, // ext pulse
  input wire logic [24:0] flags_out, // flags
  input wire logic [4:0] pointer_out, // cursor
  input wire logic [7:0] rom_addr_out // fetch address
);
  // ****************************************************************
  // fetch, word timing and pulses
  // ****************************************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  read_gap_a: assert property (rom_read_out |=> !rom_read_out [*2]) else $error("fetch too close");
  addr_hold_a: assert property (rom_read_out |-> $stable(rom_addr_out)) else $error("addr moved");
  exec_len_a: assert property (word_sync_out |-> ##27 rom_read_out) else $error("word length");
  valid_in_exec_a: assert property (result_valid_out |-> !rom_read_out && !word_sync_out) else $error("stray write");
  sync_pulse_a: assert property (word_sync_out |=> !word_sync_out) else $error("sync too long");
  ext_pulse_a: assert property (ext_strobe_out |=> !ext_strobe_out) else $error("ext too long");
  ptr_range_a: assert property (pointer_out <= 5'h18) else $error("cursor out of range");
  flag_hold_a: assert property (word_sync_out |=> $stable(flags_out) [*8]) else $error("flags moved");
  reset_state_a: assert property (disable iff (1'b0) !resetn_in |=> rom_addr_out == 8'h00 && flags_out == 25'h0000000 && !rom_read_out) else $error("reset state");
  cover property (word_sync_out);
  cover property (ext_strobe_out);
  cover property ($changed(flags_out));
endmodule
bind bsc_core_top bsc_core_props chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .rom_read_out(rom_read_out),
  .word_sync_out(word_sync_out), .result_valid_out(result_valid_out), .ext_strobe_out(ext_strobe_out),
  .flags_out(flags_out), .pointer_out(pointer_out), .rom_addr_out(rom_addr_out));
`default_nettype wire

// ### verification/bsc_rom_model.sv
// Purpose: bank of program roms facing the core
// Assumes: bench fills mem before each fetch
// Notes: outside a fetch the bus churns every cycle
`timescale 1ns/1ns
`default_nettype none
module bsc_rom_model (
  input wire logic clk_in, // core clock
  input wire logic [7:0] addr_in, // fetch address
  input wire logic [4:0] bank_in, // selected rom
  input wire logic read_in, // fetch strobe
  output logic [11:0] data_out // word of selected rom
);
  logic [11:0] mem [0:8191];
  logic [11:0] noise_r = 12'hA5C;
  // churn so an idle bus is never mistaken for data
  always @(posedge clk_in) begin
    noise_r <= ~{noise_r[10:0], noise_r[11]};
  end
  // only the selected rom answers the shared address
  assign data_out = read_in ? mem[{bank_in, addr_in}] : noise_r;
endmodule
`default_nettype wire

// ### verification/bsc_core_test.sv
// Purpose: self-checking bench of the bcd serial core
// Assumes: one instruction placed at each fetch address
// Notes: digits collected by position after word sync
`timescale 1ns/1ns
`default_nettype none
module bsc_core_test;
  import bsc_pkg::*;
  logic clk = 0, rstn = 0, rd_s, sync, vld, win, xs;
  logic [24:0] sw = 0, fl, v;
  logic [11:0] rd;
  logic [7:0] addr, b;
  logic [4:0] bank, ptr;
  logic [3:0] dig;
  logic [5:0] xc;
  logic [99:0] r [4], got;
  int bad_count = 0, samples_checked = 0, c = 0, xn = 0, vn = 0, wn = 0, n;
  always #4 clk = ~clk;
  bsc_core_top dut (.sys_clk_in(clk), .resetn_in(rstn), .rom_data_in(rd), .mode_switch_in(sw),
    .rom_addr_out(addr), .rom_bank_out(bank), .rom_read_out(rd_s), .word_sync_out(sync),
    .field_window_out(win), .result_digit_out(dig), .result_valid_out(vld), .flags_out(fl),
    .pointer_out(ptr), .ext_cmd_out(xc), .ext_strobe_out(xs));
  bsc_rom_model rom (.clk_in(clk), .addr_in(addr), .bank_in(bank), .read_in(rd_s), .data_out(rd));
  // ****************************************************************
  // monitor and helpers
  // ****************************************************************
  always @(posedge clk) begin
    c <= sync ? 0 : c + 1;
    if (vld === 1'b1) begin
      got[4*(c-1) +: 4] <= dig;
      vn <= vn + 1;
    end
    if (xs === 1'b1) xn <= xn + 1;
    if (win === 1'b1) wn <= wn + 1;
  end
  task automatic chk(string nm, logic [99:0] e, logic [99:0] a);
    samples_checked++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, a);
    end
  endtask
  task automatic summarize;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // wait for a fetch, plant the word, wait for the next fetch
  task automatic ex(logic [11:0] w);
    int i;
    for (i = 0; rd_s !== 1'b1 && i < 99; i++) @(negedge clk);
    rom.mem[{bank, addr}] = w;
    got = '0;
    vn = 0;
    wn = 0;
    @(negedge clk);
    for (i = 0; rd_s !== 1'b1 && i < 99; i++) @(negedge clk);
    if (i == 99) chk("fetch", 1, 0);
  endtask
  task automatic ctl(int s, int o);
    ex({3'b101, 4'(s), 5'(o)});
  endtask
  function automatic logic [99:0] bcd(logic [99:0] a, logic [99:0] q, bit sub, bit ci);
    int s;
    for (int k = 0; k < 25; k++) begin
      s = sub ? int'(a[4*k+:4]) - int'(q[4*k+:4]) - ci : a[4*k+:4] + q[4*k+:4] + ci;
      ci = sub ? s < 0 : s > 9;
      a[4*k+:4] = 4'(s < 0 ? s + 10 : s > 9 ? s - 10 : s);
    end
    return a;
  endfunction
  task automatic aop(int op, int s, int d, int lit);
    logic [99:0] a, q, e;
    a = r[0];
    q = r[s];
    case (op)
      0: e = bcd(a, q, 0, 0);
      1: e = bcd(a, q, 1, 0);
      3: e = bcd('0, q, 1, 0);
      4: e = bcd(q, '0, 0, 1);
      5: e = bcd(q, '0, 1, 1);
      6: e = q << 4;
      7: e = q >> 4;
      8: e = '0;
      9: e = {a[95:0], 4'(lit)};
      default: e = a;
    endcase
    ex(op == 9 ? {5'h09, 4'(lit), 3'h0} : {1'b0, 4'(op), 2'(s), 2'(d), 3'h0});
    chk("word", e, got);
    if (op == 2) begin
      r[d] = a;
      r[0] = q;
    end else begin
      r[op > 8 ? 0 : op > 5 ? s : d] = e;
    end
  endtask
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(13980));
    repeat (10) @(negedge clk);
    chk("reset", 0, {addr, fl, ptr});
    rstn = 1;
    for (int i = 0; i < 4; i++) aop(8, i, 0, 0);
    for (int w = 0; w < 8; w++) begin
      ex({5'h08, 4'h0, 3'(w)});
      chk("window", $countones(WIN_MASK[w]), vn);
      chk("window flag", $countones(WIN_MASK[w]), wn);
    end
    aop(5, 1, 2, 0);
    aop(9, 0, 0, 9);
    aop(9, 0, 0, 9);
    aop(4, 0, 3, 0);
    for (int i = 0; i < 14; i++) aop($urandom_range(9), $urandom_range(3), $urandom_range(3), $urandom_range(9));
    $display("arithmetic done");
    n = $urandom_range(24);
    ctl(0, n);
    ctl(0, (n + 7) % 25);
    ctl(1, (n + 7) % 25);
    chk("set", 100'(25'h1 << n), 100'(fl));
    ctl(4, (n + 3) % 25);
    chk("toggle", 100'((25'h1 << n) | (25'h1 << ((n + 3) % 25))), 100'(fl));
    ctl(2, 0);
    chk("clear", 0, 100'(fl));
    v = 25'($urandom);
    sw = v;
    ctl(6, 0);
    sw = ~v;
    ctl(5, 0);
    chk("latch", 100'(v), 100'(fl));
    ctl(7, 24);
    ctl(9, 0);
    chk("left", 0, 100'(ptr));
    ctl(10, 0);
    chk("right", 24, 100'(ptr));
    $display("flags and cursor done");
    ex(12'h855);
    chk("jump", 100'(8'h55), 100'(addr));
    ctl(0, n);
    ctl(3, n);
    ex(12'h830);
    chk("taken", 100'(8'h30), 100'(addr));
    ctl(1, n);
    ctl(3, n);
    b = addr;
    ex(12'h870);
    chk("fall", 100'(b + 8'h01), 100'(addr));
    b = addr;
    ctl(11, 0);
    ex(12'h8A0);
    ctl(13, 0);
    chk("recall", 100'(b + 8'h01), 100'(addr));
    ctl(7, 5);
    ex(12'h901);
    ctl(8, 9);
    ex(12'h860);
    chk("three way", 100'(8'h61), 100'(addr));
    n = xn;
    ex(12'hC2B);
    chk("ext", 100'({6'h2B, 32'(n + 1)}), 100'({xc, 32'(xn)}));
    ex(12'hF13);
    chk("bank", 100'(5'h13), 100'(bank));
    ex(12'h844);
    chk("bank fetch", 100'(8'h44), 100'(addr));
    $display("control done");
    summarize();
  end
endmodule
`default_nettype wire
